// [include/eesq_regs.vh]
// register offsets, field positions, codes and reset values of eesq_top
`ifndef EESQ_REGS_VH
`define EESQ_REGS_VH

// register byte offsets on the apb bus
`define EESQ_A_STATUS 8'h00
`define EESQ_A_SPC 8'h04
`define EESQ_A_SSR 8'h08
`define EESQ_A_VBR 8'h0C
`define EESQ_A_EXCEPTION_CODE 8'h10
`define EESQ_A_INTERRUPT_CODE 8'h14
`define EESQ_A_INTERRUPT_CODE_COPY 8'h18
`define EESQ_A_TEA 8'h1C
`define EESQ_A_PAGE_ENTRY_HIGH 8'h20
`define EESQ_A_MMU_CONTROL 8'h24
`define EESQ_A_TRA 8'h28
`define EESQ_A_CTRL 8'h2C

// status word fields
`define EESQ_SR_MD 30
`define EESQ_SR_RB 29
`define EESQ_SR_BL 28
`define EESQ_SR_IM_LSB 4
`define EESQ_SR_ENTRY 32'h7000_0000
`define EESQ_SR_INIT 32'h7000_00F0

// other fields
`define EESQ_CTRL_BYPASS 0
`define EESQ_RC_LSB 0
`define EESQ_VPN_LSB 10
`define EESQ_CODE_W 12
`define EESQ_TRA_W 10

// reset values and fixed addresses
`define EESQ_VBR_INIT 32'h0000_0000
`define EESQ_RESET_PC 32'hA000_0000
`define EESQ_USER_TOP 32'h8000_0000
`define EESQ_OFF_INT 32'h0000_0600
`define EESQ_OFF_MISS 32'h0000_0400
`define EESQ_OFF_GEN 32'h0000_0100
`define EESQ_UNDEF_NIB 4'hF

// event codes
`define EESQ_C_POR 12'h000
`define EESQ_C_MAN 12'h020
`define EESQ_C_TLB_R 12'h040
`define EESQ_C_TLB_W 12'h060
`define EESQ_C_IPW 12'h080
`define EESQ_C_PROT_R 12'h0A0
`define EESQ_C_PROT_W 12'h0C0
`define EESQ_C_ADR_R 12'h0E0
`define EESQ_C_ADR_W 12'h100
`define EESQ_C_TRAP 12'h160
`define EESQ_C_ILL 12'h180
`define EESQ_C_SLOT 12'h1A0
`define EESQ_C_BRK 12'h1E0
`define EESQ_C_DMA 12'h5C0

// access sizes
`define EESQ_SZ_WORD 2'b01
`define EESQ_SZ_LONG 2'b10

`endif

// [logic/eesq_top.v]
// exception and interrupt entry sequencer with apb register access
//
// Functional notes
// RULE1 - interrupts taken only at instruction boundary; pc and status saved
// RULE2 - interrupt entry sets mask, privilege, bank bits and both codes
// RULE3 - interrupt entry fetches from vector base plus 0x600
// RULE4 - mask bit blocks events except unmaskable interrupt with bypass set
// RULE5 - exceptions save state, vector 0x400 for miss, else 0x100
// RULE6 - power-on pin low: code 0, base cleared, status init, fetch reset pc
// RULE7 - manual reset pin low: code 0x020, otherwise as power-on
// RULE8 - during pin reset: indicator low, both state outputs high
// RULE9 - debug reset command acts as power-on reset with code 0
// RULE10 - translation fault records address, page number, keeps space id
// RULE11 - miss: increment counter if all ways valid, else first invalid
// RULE12 - no match: code 0x040 read or 0x060 write, miss vector
// RULE13 - match but unusable: counter gets way, read/write code, 0x100
// RULE14 - store to unwritten page: code 0x080, counter gets hit way
// RULE15 - access rights check for privileged and user mode
// RULE16 - rights violation: code 0x0A0 or 0x0C0, counter gets hit way
// RULE17 - address errors record fault address, code 0x0E0 or 0x100
// RULE18 - soft call saves next pc, operand is 4x immediate, code 0x160
// RULE19 - undefined or user privileged op outside slot: code 0x180
// RULE20 - illegal op in delay slot: code 0x1A0, saves branch pc
// RULE21 - user break: code 0x1E0, pc chosen by break timing
// RULE22 - dma misalignment: code 0x5C0, saves next pc
// RULE23 - exception while masked resets core state, jumps to reset pc
// RULE24 - masked ordinary interrupt stays pending until mask cleared
// RULE25 - resets beat exceptions beat interrupts; one entry per cycle
`timescale 1ns/1ns
`include "eesq_regs.vh"

module eesq_top #(
  parameter NWAY = 4,
  parameter RCW = 2,
  parameter AW = 8
) (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [AW-1:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // reset pins and debug port
  input wire poweron_reset_pin_n,
  input wire manual_reset_pin_n,
  input wire debug_reset_req,
  output wire reset_indicator_output_n,
  output wire state_out_0,
  output wire state_out_1,
  // pipeline
  input wire boundary,
  input wire [31:0] cur_pc,
  input wire [31:0] next_pc,
  input wire [31:0] branch_pc,
  input wire fetch_valid,
  input wire [31:0] fetch_addr,
  input wire dec_valid,
  input wire [15:0] dec_opcode,
  input wire dec_in_slot,
  input wire dec_priv,
  input wire dec_pc_write,
  input wire trap_valid,
  input wire [7:0] trap_imm,
  // interrupt request
  input wire irq_req,
  input wire irq_unmaskable,
  input wire [11:0] irq_code,
  output wire irq_ack,
  // memory access and translation lookup
  input wire mem_valid,
  input wire mem_write,
  input wire [1:0] mem_size,
  input wire [31:0] mem_addr,
  input wire [NWAY-1:0] way_hit,
  input wire [NWAY-1:0] way_valid,
  input wire hit_usable,
  input wire hit_written,
  input wire [1:0] hit_rights,
  // break and dma
  input wire brk_valid,
  input wire brk_post,
  input wire dma_valid,
  input wire [1:0] dma_size,
  input wire [1:0] dma_addr_lo,
  // fetch redirection
  output wire fetch_redirect,
  output wire [31:0] fetch_target,
  output wire core_reset
);

  localparam ST_RUN = 2'b01;
  localparam ST_RST = 2'b10;

  reg [1:0] state_q;
  reg [1:0] pin_s1_q;
  reg [1:0] pin_s2_q;
  reg [31:0] status_q;
  reg [31:0] spc_q;
  reg [31:0] ssr_q;
  reg [31:0] vbr_q;
  reg [11:0] exception_code_q;
  reg [11:0] interrupt_code_q;
  reg [11:0] interrupt_code_copy_q;
  reg [31:0] tea_q;
  reg [31:0] page_entry_high_q;
  reg [31:0] mmu_control_q;
  reg [9:0] tra_q;
  reg [31:0] ctrl_q;
  reg [31:0] prdata_q;
  reg [31:0] target_q;
  reg redirect_q;
  reg core_rst_q;

  // misaligned word or longword access
  function misal;
    input [1:0] lo;
    input [1:0] sz;
    begin
      misal = ((sz == `EESQ_SZ_WORD) && lo[0]) ||
              ((sz == `EESQ_SZ_LONG) && (lo != 2'b00));
    end
  endfunction

  // index of lowest set bit, zero when none
  function [RCW-1:0] first_one;
    input [NWAY-1:0] v;
    integer i;
    begin
      first_one = {RCW{1'b0}};
      for (i = NWAY - 1; i >= 0; i = i - 1) begin
        if (v[i]) begin
          first_one = i[RCW-1:0];
        end
      end
    end
  endfunction

  // rights: bit1 opens user access, bit0 opens writes
  function rights_ok;
    input [1:0] pr;
    input priv;
    input wr;
    begin
      rights_ok = (priv | pr[1]) & (~wr | pr[0]);
    end
  endfunction

  // register map decode, shared by read and write paths
  function addr_ok;
    input [AW-1:0] a;
    begin
      case (a)
        `EESQ_A_STATUS, `EESQ_A_SPC, `EESQ_A_SSR, `EESQ_A_VBR,
        `EESQ_A_EXCEPTION_CODE, `EESQ_A_INTERRUPT_CODE, `EESQ_A_INTERRUPT_CODE_COPY, `EESQ_A_TEA,
        `EESQ_A_PAGE_ENTRY_HIGH, `EESQ_A_MMU_CONTROL, `EESQ_A_TRA,
        `EESQ_A_CTRL: addr_ok = 1'b1;
        default: addr_ok = 1'b0;
      endcase
    end
  endfunction

  // status fields
  wire bl = status_q[`EESQ_SR_BL];
  wire priv = status_q[`EESQ_SR_MD];
  wire user = ~priv;
  wire bypass = ctrl_q[`EESQ_CTRL_BYPASS];
  wire [RCW-1:0] rc = mmu_control_q[`EESQ_RC_LSB +: RCW];
  wire por_n = pin_s2_q[0];
  wire pin_rst = ~pin_s2_q[0] | ~pin_s2_q[1];
  wire in_rst = state_q[1];

  // translation and address checks
  wire hit = |way_hit;
  wire [RCW-1:0] hit_way = first_one(way_hit);
  wire [RCW-1:0] free_way = first_one(~way_valid);
  wire all_valid = &way_valid;
  wire ok_rt = rights_ok(hit_rights, priv, mem_write); // [RULE15]
  wire m_user = user & (mem_addr >= `EESQ_USER_TOP);
  wire m_aerr = mem_valid & (misal(mem_addr[1:0], mem_size) | m_user);
  wire m_miss = mem_valid & ~hit;
  wire m_inval = mem_valid & hit & ~hit_usable;
  wire m_prot = mem_valid & hit & hit_usable & ~ok_rt;
  wire m_ipw = mem_valid & hit & hit_usable & ok_rt & mem_write &
               ~hit_written;
  wire f_user = user & (fetch_addr >= `EESQ_USER_TOP);
  wire f_aerr = fetch_valid & (fetch_addr[0] | f_user); // [RULE17]
  wire undef = dec_opcode[15:12] == `EESQ_UNDEF_NIB;
  wire bad_op = undef | (dec_priv & user);
  wire d_ill = dec_valid & ~dec_in_slot & bad_op; // [RULE19]
  wire d_slot = dec_valid & dec_in_slot & (bad_op | dec_pc_write); // [RULE20]
  wire brk_eff = brk_valid & ~bl; // no break trap while masked
  wire dma_err = dma_valid & misal(dma_addr_lo, dma_size); // [RULE22]

  // exception selection; one winner per cycle
  reg ex_take;
  reg [11:0] ex_code;
  reg [31:0] ex_off;
  reg [31:0] ex_spc;
  reg ex_tea;
  reg ex_vpn;
  reg ex_rc;
  reg [RCW-1:0] ex_rc_val;
  always @* begin
    ex_take = 1'b1;
    ex_code = `EESQ_C_POR;
    ex_off = `EESQ_OFF_GEN; // [RULE5]
    ex_spc = cur_pc;
    ex_tea = 1'b0;
    ex_vpn = 1'b0;
    ex_rc = 1'b0;
    ex_rc_val = hit_way;
    if (f_aerr) begin
      ex_code = `EESQ_C_ADR_R; // [RULE17]
      ex_spc = fetch_addr;
      ex_tea = 1'b1;
    end else if (d_slot) begin
      ex_code = `EESQ_C_SLOT; // [RULE20]
      ex_spc = branch_pc;
    end else if (d_ill) begin
      ex_code = `EESQ_C_ILL; // [RULE19]
    end else if (trap_valid) begin
      ex_code = `EESQ_C_TRAP; // [RULE18]
      ex_spc = next_pc;
    end else if (m_aerr) begin
      ex_code = mem_write ? `EESQ_C_ADR_W : `EESQ_C_ADR_R; // [RULE17]
      ex_tea = 1'b1;
    end else if (m_miss) begin
      ex_code = mem_write ? `EESQ_C_TLB_W : `EESQ_C_TLB_R; // [RULE12]
      ex_off = `EESQ_OFF_MISS; // [RULE5]
      ex_tea = 1'b1;
      ex_vpn = 1'b1;
      ex_rc = 1'b1;
      // [RULE11]
      ex_rc_val = all_valid ? rc + {{(RCW-1){1'b0}}, 1'b1} : free_way;
    end else if (m_inval) begin
      ex_code = mem_write ? `EESQ_C_TLB_W : `EESQ_C_TLB_R; // [RULE13]
      ex_tea = 1'b1;
      ex_vpn = 1'b1;
      ex_rc = 1'b1;
    end else if (m_prot) begin
      ex_code = mem_write ? `EESQ_C_PROT_W : `EESQ_C_PROT_R; // [RULE16]
      ex_tea = 1'b1;
      ex_vpn = 1'b1;
      ex_rc = 1'b1;
    end else if (m_ipw) begin
      ex_code = `EESQ_C_IPW; // [RULE14]
      ex_tea = 1'b1;
      ex_vpn = 1'b1;
      ex_rc = 1'b1;
    end else if (brk_eff) begin
      ex_code = `EESQ_C_BRK; // [RULE21]
      ex_spc = brk_post ? next_pc : cur_pc;
    end else if (dma_err) begin
      ex_code = `EESQ_C_DMA; // [RULE22]
      ex_spc = next_pc;
    end else begin
      ex_take = 1'b0;
    end
  end

  // interrupt acceptance; a masked request just stays waiting
  wire int_ok = ~bl | (irq_unmaskable & bypass); // [RULE4] [RULE24]
  wire int_take = boundary & irq_req & int_ok; // [RULE1]
  wire run = ~in_rst & ~pin_rst & ~debug_reset_req;
  assign irq_ack = run & ~ex_take & int_take; // [RULE25]

  // apb: zero wait states, read data captured in the setup phase
  wire wr_en = psel & penable & pwrite & addr_ok(paddr);
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addr_ok(paddr);
  assign prdata = prdata_q;

  // read mux; unmapped offsets read as zero
  reg [31:0] rd_mux;
  always @* begin
    case (paddr)
      `EESQ_A_STATUS: rd_mux = status_q;
      `EESQ_A_SPC: rd_mux = spc_q;
      `EESQ_A_SSR: rd_mux = ssr_q;
      `EESQ_A_VBR: rd_mux = vbr_q;
      `EESQ_A_EXCEPTION_CODE: rd_mux = {20'h0_0000, exception_code_q};
      `EESQ_A_INTERRUPT_CODE: rd_mux = {20'h0_0000, interrupt_code_q};
      `EESQ_A_INTERRUPT_CODE_COPY: rd_mux = {20'h0_0000, interrupt_code_copy_q};
      `EESQ_A_TEA: rd_mux = tea_q;
      `EESQ_A_PAGE_ENTRY_HIGH: rd_mux = page_entry_high_q;
      `EESQ_A_MMU_CONTROL: rd_mux = mmu_control_q;
      `EESQ_A_TRA: rd_mux = {22'h00_0000, tra_q};
      `EESQ_A_CTRL: rd_mux = ctrl_q;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // reset pins come from outside, two flops before any use
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_q <= 2'b00;
      pin_s2_q <= 2'b00;
    end else begin
      pin_s1_q <= {manual_reset_pin_n, poweron_reset_pin_n};
      pin_s2_q <= pin_s1_q;
    end
  end

  // pin reset state; indicator follows it, state pins also go high on core reset
  assign reset_indicator_output_n = ~in_rst; // [RULE8]
  assign state_out_0 = in_rst | core_rst_q; // [RULE8]
  assign state_out_1 = in_rst | core_rst_q;
  assign fetch_redirect = redirect_q;
  assign fetch_target = target_q;
  assign core_reset = core_rst_q;

  // main sequencer; software writes first, hardware events override
  // them in the same cycle so an event is never lost to a write
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_RST;
      status_q <= `EESQ_SR_INIT;
      spc_q <= 32'h0000_0000;
      ssr_q <= 32'h0000_0000;
      vbr_q <= `EESQ_VBR_INIT;
      exception_code_q <= `EESQ_C_POR;
      interrupt_code_q <= 12'h000;
      interrupt_code_copy_q <= 12'h000;
      tea_q <= 32'h0000_0000;
      page_entry_high_q <= 32'h0000_0000;
      mmu_control_q <= 32'h0000_0000;
      tra_q <= 10'h000;
      ctrl_q <= 32'h0000_0000;
      prdata_q <= 32'h0000_0000;
      target_q <= `EESQ_RESET_PC;
      redirect_q <= 1'b0;
      core_rst_q <= 1'b0;
    end else begin
      redirect_q <= 1'b0;
      core_rst_q <= 1'b0;
      if (psel && !penable) begin
        prdata_q <= rd_mux;
      end
      if (wr_en) begin
        case (paddr)
          `EESQ_A_STATUS: status_q <= pwdata;
          `EESQ_A_SPC: spc_q <= pwdata;
          `EESQ_A_SSR: ssr_q <= pwdata;
          `EESQ_A_VBR: vbr_q <= pwdata;
          `EESQ_A_EXCEPTION_CODE: exception_code_q <= pwdata[11:0];
          `EESQ_A_INTERRUPT_CODE: interrupt_code_q <= pwdata[11:0];
          `EESQ_A_TEA: tea_q <= pwdata;
          `EESQ_A_PAGE_ENTRY_HIGH: page_entry_high_q <= pwdata;
          `EESQ_A_MMU_CONTROL: mmu_control_q <= pwdata;
          `EESQ_A_TRA: tra_q <= pwdata[9:0];
          `EESQ_A_CTRL: ctrl_q <= pwdata;
          default: ;
        endcase
      end
      case (state_q)
        ST_RST: begin
          // held while a pin is low; fetch restarts on release
          if (pin_rst) begin
            exception_code_q <= por_n ? `EESQ_C_MAN : `EESQ_C_POR; // [RULE6] [RULE7]
            vbr_q <= `EESQ_VBR_INIT;
            status_q <= `EESQ_SR_INIT;
          end else begin
            state_q <= ST_RUN;
            redirect_q <= 1'b1;
            target_q <= `EESQ_RESET_PC; // [RULE6]
          end
        end
        ST_RUN: begin
          if (pin_rst) begin
            state_q <= ST_RST; // [RULE25]
            exception_code_q <= por_n ? `EESQ_C_MAN : `EESQ_C_POR; // [RULE7]
            vbr_q <= `EESQ_VBR_INIT;
            status_q <= `EESQ_SR_INIT;
          end else if (debug_reset_req) begin
            exception_code_q <= `EESQ_C_POR; // [RULE9]
            vbr_q <= `EESQ_VBR_INIT;
            status_q <= `EESQ_SR_INIT;
            redirect_q <= 1'b1;
            target_q <= `EESQ_RESET_PC;
          end else if (ex_take && bl) begin
            // nested exception: core state back to reset values only
            status_q <= `EESQ_SR_INIT; // [RULE23]
            vbr_q <= `EESQ_VBR_INIT;
            core_rst_q <= 1'b1;
            redirect_q <= 1'b1;
            target_q <= `EESQ_RESET_PC; // [RULE23]
          end else if (ex_take) begin
            spc_q <= ex_spc; // [RULE5]
            ssr_q <= status_q;
            status_q <= status_q | `EESQ_SR_ENTRY;
            exception_code_q <= ex_code;
            redirect_q <= 1'b1;
            target_q <= vbr_q + ex_off;
            if (ex_tea) begin
              tea_q <= f_aerr ? fetch_addr : mem_addr; // [RULE10]
            end
            if (ex_vpn) begin
              // page number only; the space id field is left alone
              page_entry_high_q[31:`EESQ_VPN_LSB] <= mem_addr[31:`EESQ_VPN_LSB];
            end
            if (ex_rc) begin
              mmu_control_q[`EESQ_RC_LSB +: RCW] <= ex_rc_val; // [RULE11]
            end
            if (trap_valid && !f_aerr && !d_slot && !d_ill) begin
              tra_q <= {trap_imm, 2'b00}; // [RULE18]
            end
          end else if (int_take) begin
            spc_q <= next_pc; // [RULE1]
            ssr_q <= status_q;
            status_q <= status_q | `EESQ_SR_ENTRY; // [RULE2]
            interrupt_code_q <= irq_code; // [RULE2]
            interrupt_code_copy_q <= irq_code;
            redirect_q <= 1'b1;
            target_q <= vbr_q + `EESQ_OFF_INT; // [RULE3]
          end
        end
        default: begin
          state_q <= ST_RST;
        end
      endcase
    end
  end

endmodule // eesq_top

// [tb/eesq_chk.sv]
// port-level assertions for the exception entry sequencer
`timescale 1ns/1ns
module eesq_chk (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // reset pins and status outputs
  input wire poweron_reset_pin_n,
  input wire manual_reset_pin_n,
  input wire debug_reset_req,
  input wire reset_indicator_output_n,
  input wire state_out_0,
  input wire state_out_1,
  // events and fetch redirection
  input wire boundary,
  input wire trap_valid,
  input wire dma_valid,
  input wire irq_ack,
  input wire fetch_redirect,
  input wire [31:0] fetch_target,
  input wire core_reset
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // raw pins and the reset indicator; the synchroniser lag is covered by the bench's spacing
  wire run = reset_indicator_output_n && poweron_reset_pin_n
    && manual_reset_pin_n;
  // jump to the fixed reset address
  sequence s_rst_jump;
    fetch_redirect && fetch_target == 32'hA000_0000;
  endsequence
  sequence s_pin_low;
    (!poweron_reset_pin_n || !manual_reset_pin_n) [*4];
  endsequence
  property p_pin_state;
    s_pin_low |-> !reset_indicator_output_n && state_out_0 && state_out_1;
  endproperty
  a_pin_state: assert property (p_pin_state)
    else $error("pin reset outputs wrong");
  property p_rst_fetch;
    $rose(reset_indicator_output_n) |-> ##[0:1] s_rst_jump;
  endproperty
  a_rst_fetch: assert property (p_rst_fetch)
    else $error("no fetch from reset address after pin reset");
  property p_dbg;
    debug_reset_req && run |=> s_rst_jump;
  endproperty
  a_dbg: assert property (p_dbg)
    else $error("debug reset did not jump to reset address");
  property p_core;
    core_reset |-> s_rst_jump and (state_out_0 && state_out_1);
  endproperty
  a_core: assert property (p_core)
    else $error("core reset without reset jump");
  property p_irq_bnd;
    irq_ack |-> boundary;
  endproperty
  a_irq_bnd: assert property (p_irq_bnd)
    else $error("interrupt taken off a boundary");
  property p_irq_vec;
    irq_ack |=> fetch_redirect && fetch_target[11:0] == 12'h600;
  endproperty
  a_irq_vec: assert property (p_irq_vec)
    else $error("interrupt vector offset wrong");
  property p_prio;
    irq_ack |-> !(trap_valid || dma_valid || debug_reset_req);
  endproperty
  a_prio: assert property (p_prio)
    else $error("interrupt taken over an exception");
  property p_exc;
    trap_valid && run |=> fetch_redirect;
  endproperty
  a_exc: assert property (p_exc)
    else $error("exception without fetch redirect");
endmodule // eesq_chk

// [tb/eesq_pipe_model.sv]
// behavioural pipeline model supplying pcs and instruction boundaries
`timescale 1ns/1ns
module eesq_pipe_model (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // bench control and redirection
  input wire stall,
  input wire fetch_redirect,
  input wire [31:0] fetch_target,
  // instruction flow
  output logic boundary,
  output logic [31:0] cur_pc,
  output logic [31:0] next_pc,
  output logic [31:0] branch_pc
);
  logic [31:0] pc_q;
  // a stall keeps the instruction in flight, so pcs hold still
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_q <= 32'hA000_0000;
    end else if (fetch_redirect) begin
      pc_q <= fetch_target;
    end else if (!stall) begin
      pc_q <= pc_q + 32'h0000_0002;
    end
  end
  // 16-bit instructions; a slot's branch sits just before it
  assign boundary = !stall;
  assign cur_pc = pc_q;
  assign next_pc = pc_q + 32'h0000_0002;
  assign branch_pc = pc_q - 32'h0000_0002;
endmodule // eesq_pipe_model

// [tb/eesq_top_tb.sv]
// self-checking bench for the exception entry sequencer
`timescale 1ns/1ns
`include "eesq_regs.vh"
module eesq_top_tb;
  localparam logic [31:0] VB = 32'h0000_2000;
  localparam logic [31:0] MS = 32'h0000_0400;
  localparam logic [31:0] GN = 32'h0000_0100;
  // clock, reset and apb
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, sr_old;
  logic pready, pslverr, core_reset, irq_ack;
  // pins, status and pipeline model
  logic poweron_reset_pin_n = 0, manual_reset_pin_n = 1;
  logic debug_reset_req = 0, reset_indicator_output_n;
  logic state_out_0, state_out_1, stall = 1, boundary, fetch_redirect;
  logic [31:0] cur_pc, next_pc, branch_pc, fetch_target;
  // events
  logic dec_valid = 0, dec_in_slot = 0, dec_pc_write = 0, trap_valid = 0;
  logic [15:0] dec_opcode = 0;
  logic [7:0] trap_imm = 0;
  logic irq_req = 0, irq_unmaskable = 0;
  logic [11:0] irq_code = 0;
  logic mem_valid = 0, mem_write = 0, hit_usable = 0, hit_written = 0;
  logic [1:0] mem_size = 0, hit_rights = 0, dma_size = 0, dma_addr_lo = 0;
  logic [31:0] mem_addr = 0, fetch_addr = 0;
  logic [3:0] way_hit = 0, way_valid = 0;
  logic brk_valid = 0, brk_post = 0, dma_valid = 0, fetch_valid = 0;
  int miscompares = 0, cmp_count = 0;

  eesq_top eesq_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .poweron_reset_pin_n,
    .manual_reset_pin_n, .debug_reset_req, .reset_indicator_output_n,
    .state_out_0, .state_out_1, .boundary, .cur_pc, .next_pc, .branch_pc,
    .fetch_valid, .fetch_addr, .dec_valid, .dec_opcode,
    .dec_in_slot, .dec_priv(1'b0), .dec_pc_write, .trap_valid, .trap_imm,
    .irq_req, .irq_unmaskable, .irq_code, .irq_ack, .mem_valid, .mem_write,
    .mem_size, .mem_addr, .way_hit, .way_valid, .hit_usable, .hit_written,
    .hit_rights, .brk_valid, .brk_post, .dma_valid, .dma_size, .dma_addr_lo,
    .fetch_redirect, .fetch_target, .core_reset);
  eesq_pipe_model eesq_pipe_model_i (.pclk, .presetn, .stall,
    .fetch_redirect, .fetch_target, .boundary, .cur_pc, .next_pc,
    .branch_pc);

  // 10 MHz clock
  initial begin
    forever #50 pclk = ~pclk;
  end

  task give_verdict;
    if (miscompares == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input [31:0] got, exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s exp %h got %h", what, exp, got);
    end
  endtask
  // one apb transfer; request held until pready is seen high
  task apb(input w, input [7:0] a, input [31:0] wd, output [31:0] rd);
    int n;
    n = 0;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, wd};
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1 && n++ < 20);
    if (n >= 20) begin
      miscompares++;
      give_verdict;
    end
    rd = prdata;
    {psel, penable} <= 2'b00;
  endtask
  task wr(input [7:0] a, input [31:0] d);
    logic [31:0] x;
    apb(1, a, d, x);
  endtask
  task rdc(input [7:0] a, input [31:0] e, input string what);
    logic [31:0] x;
    apb(0, a, 0, x);
    chk(x, e, what);
  endtask
  // bounded wait for an interrupt ack or a fetch redirect
  task wait_hi(input sel);
    int n;
    n = 0;
    do @(negedge pclk);
    while ((sel ? irq_ack : fetch_redirect) !== 1'b1 && n++ < 40);
    if (n >= 40) begin
      miscompares++;
      give_verdict;
    end
  endtask
  // clear the mask bit; p selects privileged mode
  task arm(input p);
    sr_old = p ? 32'h4000_0000 : 32'h0000_0000;
    wr(`EESQ_A_STATUS, sr_old);
  endtask
  // event was raised on the last edge: drop it and judge the entry
  task take(input [11:0] c, input [31:0] t, s);
    @(posedge pclk);
    {mem_valid, trap_valid, dec_valid, brk_valid, dma_valid,
      fetch_valid} <= 6'h00;
    @(negedge pclk);
    chk(fetch_redirect, 1, "redir");
    chk(fetch_target, t, "tgt");
    rdc(`EESQ_A_EXCEPTION_CODE, c, "exp");
    rdc(`EESQ_A_SPC, s, "spc");
    rdc(`EESQ_A_SSR, sr_old, "ssr");
    rdc(`EESQ_A_STATUS, `EESQ_SR_ENTRY, "sr");
  endtask
  task mem_ev(input p, w, input [1:0] sz, input [31:0] a,
    input [3:0] h, v, input u, d, input [1:0] r, input [11:0] c,
    input [31:0] off, input [1:0] rc);
    logic [31:0] x;
    arm(p);
    {mem_valid, mem_write, mem_size, mem_addr} <= {1'b1, w, sz, a};
    {way_hit, way_valid, hit_usable, hit_written} <= {h, v, u, d};
    hit_rights <= r;
    take(c, VB + off, cur_pc);
    rdc(`EESQ_A_TEA, a, "tea");
    if (c < 12'h0E0) begin
      apb(0, `EESQ_A_PAGE_ENTRY_HIGH, 0, x);
      chk(x[31:10], a[31:10], "vpn");
      apb(0, `EESQ_A_MMU_CONTROL, 0, x);
      chk(x[1:0], rc, "rc");
    end
  endtask

  task s_reset;
    repeat (4) @(posedge pclk);
    @(negedge pclk);
    chk(reset_indicator_output_n, 0, "ind");
    chk({state_out_1, state_out_0}, 3, "st");
    rdc(`EESQ_A_EXCEPTION_CODE, `EESQ_C_POR, "exp");
    rdc(`EESQ_A_STATUS, `EESQ_SR_INIT, "sr");
    poweron_reset_pin_n <= 1;
    wait_hi(0);
    chk(fetch_target, `EESQ_RESET_PC, "tgt");
    wr(`EESQ_A_VBR, VB);
    manual_reset_pin_n <= 0;
    repeat (4) @(posedge pclk);
    rdc(`EESQ_A_EXCEPTION_CODE, `EESQ_C_MAN, "exp");
    rdc(`EESQ_A_VBR, 0, "vbr");
    rdc(`EESQ_A_STATUS, `EESQ_SR_INIT, "sr");
    manual_reset_pin_n <= 1;
    wait_hi(0);
    chk(fetch_target, `EESQ_RESET_PC, "tgt");
    wr(`EESQ_A_VBR, VB);
  endtask

  task s_irq;
    arm(1);
    {irq_req, irq_code} <= {1'b1, 12'h2A0};
    repeat (3) begin
      @(negedge pclk);
      chk(irq_ack, 0, "ack");
    end
    @(posedge pclk);
    stall <= 0;
    wait_hi(1);
    @(posedge pclk);
    {irq_req, stall} <= 2'b01;
    @(negedge pclk);
    chk(fetch_target, VB + `EESQ_OFF_INT, "tgt");
    rdc(`EESQ_A_INTERRUPT_CODE, 12'h2A0, "ev");
    rdc(`EESQ_A_INTERRUPT_CODE_COPY, 12'h2A0, "ev2");
    rdc(`EESQ_A_SSR, 32'h4000_0000, "ssr");
    rdc(`EESQ_A_STATUS, `EESQ_SR_ENTRY, "sr");
    {irq_req, stall} <= 2'b10;
    repeat (4) begin
      @(negedge pclk);
      chk(irq_ack, 0, "ack");
    end
    wr(`EESQ_A_CTRL, 32'h0000_0001);
    irq_unmaskable <= 1;
    wait_hi(1);
    @(posedge pclk);
    {irq_req, irq_unmaskable, stall} <= 3'b001;
    wr(`EESQ_A_CTRL, 32'h0000_0000);
  endtask

  task s_misc;
    arm(1);
    {trap_valid, trap_imm, irq_req, irq_code} <= {9'h125, 13'h12C0};
    stall <= 0;
    take(`EESQ_C_TRAP, VB + GN, next_pc);
    {irq_req, stall} <= 2'b01;
    rdc(`EESQ_A_TRA, 32'h0000_0094, "tra");
    rdc(`EESQ_A_INTERRUPT_CODE, 12'h2A0, "ev");
    arm(0);
    {dec_valid, dec_opcode} <= {1'b1, 16'hF123};
    take(`EESQ_C_ILL, VB + GN, cur_pc);
    arm(1);
    {dec_valid, dec_opcode, dec_in_slot, dec_pc_write} <= 19'h4_0003;
    take(`EESQ_C_SLOT, VB + GN, branch_pc);
    arm(1);
    {brk_valid, brk_post} <= 2'b11;
    take(`EESQ_C_BRK, VB + GN, next_pc);
    arm(1);
    {brk_valid, brk_post} <= 2'b10;
    take(`EESQ_C_BRK, VB + GN, cur_pc);
    arm(1);
    {fetch_valid, fetch_addr} <= {1'b1, 32'h0000_3003};
    take(`EESQ_C_ADR_R, VB + GN, 32'h0000_3003);
    rdc(`EESQ_A_TEA, 32'h0000_3003, "tea");
    arm(1);
    {dma_valid, dma_size, dma_addr_lo} <= {1'b1, `EESQ_SZ_LONG, 2'b10};
    take(`EESQ_C_DMA, VB + GN, next_pc);
    // mask still set from the dma entry: a trap now resets the core
    trap_valid <= 1;
    @(posedge pclk);
    trap_valid <= 0;
    @(negedge pclk);
    chk(core_reset, 1, "core");
    chk(fetch_target, `EESQ_RESET_PC, "tgt");
    rdc(`EESQ_A_EXCEPTION_CODE, `EESQ_C_DMA, "exp");
    rdc(`EESQ_A_STATUS, `EESQ_SR_INIT, "sr");
    arm(1);
    debug_reset_req <= 1;
    @(posedge pclk);
    debug_reset_req <= 0;
    @(negedge pclk);
    chk(fetch_redirect, 1, "redir");
    chk(fetch_target, `EESQ_RESET_PC, "tgt");
    rdc(`EESQ_A_EXCEPTION_CODE, `EESQ_C_POR, "exp");
    rdc(`EESQ_A_STATUS, `EESQ_SR_INIT, "sr");
  endtask

  // main sequence
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1;
    s_reset;
    s_irq;
    mem_ev(1, 0, 2, 32'h0000_1000, 0, 4'hB, 1, 1, 3, 12'h040, MS, 2);
    mem_ev(1, 1, 2, 32'h0000_2004, 0, 4'hF, 1, 1, 3, 12'h060, MS, 3);
    mem_ev(1, 0, 2, 32'h0000_1400, 2, 4'hF, 0, 1, 3, 12'h040, GN, 1);
    mem_ev(0, 1, 2, 32'h0000_1800, 4, 4'hF, 1, 1, 2, 12'h0C0, GN, 2);
    mem_ev(0, 0, 2, 32'h0000_1C00, 8, 4'hF, 1, 1, 0, 12'h0A0, GN, 3);
    mem_ev(1, 1, 2, 32'h0000_2400, 1, 4'hF, 1, 1, 0, 12'h0C0, GN, 0);
    mem_ev(1, 1, 2, 32'h0000_2800, 2, 4'hF, 1, 0, 1, 12'h080, GN, 1);
    mem_ev(1, 0, 1, 32'h0000_3001, 1, 4'hF, 1, 1, 3, 12'h0E0, GN, 0);
    mem_ev(0, 1, 0, 32'h8000_0000, 1, 4'hF, 1, 1, 3, 12'h100, GN, 0);
    s_misc;
    give_verdict;
  end
endmodule // eesq_top_tb

bind eesq_top eesq_chk eesq_chk_i (.pclk, .presetn, .poweron_reset_pin_n,
  .manual_reset_pin_n, .debug_reset_req, .reset_indicator_output_n,
  .state_out_0, .state_out_1, .boundary, .trap_valid, .dma_valid, .irq_ack,
  .fetch_redirect, .fetch_target, .core_reset);
